// ---- rtl/pufr_pkg.sv ----
package pufr_pkg;
   // register command codes
   localparam logic [7:0] CMD_LIMIT = 8'h62;
   localparam logic [7:0] CMD_ACTION = 8'h63;
   localparam int LIMIT_W = 16;
   localparam int ACTION_W = 8;
   localparam logic [15:0] LIMIT_RST = 16'h0000;
   localparam logic [7:0] ACTION_RST = 8'h00;
   localparam logic [15:0] RDATA_NONE = 16'h0000;
   // action byte fields
   localparam int RESP_HI = 7;
   localparam int RESP_LO = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DLY_HI = 2;
   localparam int DLY_LO = 0;
   localparam logic [1:0] RESP_IGNORE = 2'h0;
   localparam logic [1:0] RESP_RUN_RETRY = 2'h1;
   localparam logic [1:0] RESP_DIS_RETRY = 2'h2;
   localparam logic [1:0] RESP_LATCH = 2'h3;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // millisecond tick
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_TIME_US = 1000;
   localparam int MS_CYCLES = (CLK_HZ / 1_000_000) * TICK_TIME_US;
   typedef enum logic [2:0] {
      st_off, st_start, st_timing, st_run, st_hold, st_wait, st_latch
   } pufr_state_t;
endpackage

// ---- rtl/pufr_delay.sv ----
module pufr_delay #(
   parameter int UNIT_W = 8,
   parameter int CODE_W = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic start,
   input wire logic ms_tick,
   input wire logic [CODE_W-1:0] code,
   input wire logic [UNIT_W-1:0] unit_ms,
   // status
   output logic busy,
   output logic done
);
   localparam int CNT_W = UNIT_W + (1 << CODE_W) - 1;

   logic [CNT_W-1:0] remain_r;
   logic busy_r;
   logic done_r;
   wire logic [CNT_W-1:0] total;
   wire logic last_tick;

   // power-of-two decode of the delay code
   assign total = CNT_W'(unit_ms) << code;
   assign last_tick = busy_r && ms_tick && (remain_r <= CNT_W'(1));
   assign busy = busy_r;
   assign done = done_r;

   // count down whole milliseconds; a zero unit ends at the next tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         remain_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= last_tick && !start;
         if (start) begin
            remain_r <= total;
            busy_r <= 1'b1;
         end else if (last_tick) begin
            remain_r <= '0;
            busy_r <= 1'b0;
         end else if (busy_r && ms_tick) begin
            remain_r <= remain_r - CNT_W'(1);
         end
      end
   end

   dly_cause_a: assert property (@(posedge clk) disable iff (rst)
      done_r |-> $past(busy_r) && $past(ms_tick))
      else $error("delay done without a running count");
endmodule

// ---- rtl/pufr_top.sv ----
module pufr_top #(
   parameter int MS_CYCLES = pufr_pkg::MS_CYCLES,
   parameter int UNIT_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register access by command code
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_cmd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // converter sequencing inputs
   input wire logic on_cmd,
   input wire logic rise_start,
   input wire logic vout_above_uv,
   input wire logic clear_faults,
   input wire logic clear_status,
   input wire logic [UNIT_W-1:0] vout_unit_ms,
   // sequencing outputs
   output logic out_enable,
   output logic restart_pulse,
   output logic timeout_event,
   output logic timeout_fault,
   output logic [2:0] retries_left
);
   localparam int TICK_W = $clog2(MS_CYCLES);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_CYCLES - 1);

   pufr_pkg::pufr_state_t state_r;
   pufr_pkg::pufr_state_t state_nxt;
   logic [15:0] limit_r;
   logic [7:0] action_r;
   logic [15:0] rdata_r;
   logic rvalid_r;
   logic [TICK_W-1:0] tick_cnt_r;
   logic [15:0] elapsed_r;
   logic out_en_r;
   logic restart_r;
   logic event_r;
   logic fault_r;
   logic [2:0] retries_r;

   wire logic ms_tick;
   wire logic [1:0] resp;
   wire logic [2:0] retry_set;
   wire logic [2:0] dly_code;
   wire logic timeout_hit;
   wire logic retry_ok;
   wire logic clear_any;
   wire logic dly_start;
   wire logic dly_done;
   wire logic restarting;
   wire logic fresh_start;
   wire logic out_en_nxt;
   wire logic [15:0] rd_mux;

   assign resp = action_r[pufr_pkg::RESP_HI:pufr_pkg::RESP_LO];
   assign retry_set = action_r[pufr_pkg::RETRY_HI:pufr_pkg::RETRY_LO];
   assign dly_code = action_r[pufr_pkg::DLY_HI:pufr_pkg::DLY_LO];
   assign ms_tick = (tick_cnt_r == TICK_LAST);

   // limit reached while the output is still below the undervoltage limit
   assign timeout_hit = (state_r == pufr_pkg::st_timing) && on_cmd
      && !vout_above_uv && (limit_r != pufr_pkg::LIMIT_RST) && (elapsed_r >= limit_r);
   // setting 111 restarts without counting down
   assign retry_ok = (retry_set == pufr_pkg::RETRY_FOREVER) || (retries_r != 3'h0);
   // commanded off also clears, so the next on starts clean
   assign clear_any = clear_faults || clear_status || !on_cmd;
   assign restarting = (state_r == pufr_pkg::st_wait) && (state_nxt == pufr_pkg::st_start);
   assign fresh_start = (state_r == pufr_pkg::st_off) && (state_nxt == pufr_pkg::st_start);
   assign dly_start = ((state_nxt == pufr_pkg::st_hold) && (state_r != pufr_pkg::st_hold))
      || ((state_nxt == pufr_pkg::st_wait) && (state_r != pufr_pkg::st_wait));
   assign out_en_nxt = (state_nxt == pufr_pkg::st_start) || (state_nxt == pufr_pkg::st_timing)
      || (state_nxt == pufr_pkg::st_run) || (state_nxt == pufr_pkg::st_hold);
   assign rd_mux = (reg_cmd == pufr_pkg::CMD_LIMIT) ? limit_r
      : (reg_cmd == pufr_pkg::CMD_ACTION) ? {8'h00, action_r} : pufr_pkg::RDATA_NONE;

   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign out_enable = out_en_r;
   assign restart_pulse = restart_r;
   assign timeout_event = event_r;
   assign timeout_fault = fault_r;
   assign retries_left = retries_r;

   // delay unit shared with the output voltage fault
   pufr_delay #(.UNIT_W(UNIT_W), .CODE_W(3)) u_delay (
      .clk(clk),
      .rst(rst),
      .start(dly_start),
      .ms_tick(ms_tick),
      .code(dly_code),
      .unit_ms(vout_unit_ms),
      .busy(),
      .done(dly_done)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         pufr_pkg::st_off: begin
            if (on_cmd) state_nxt = pufr_pkg::st_start;
         end
         // timer begins when the rise starts
         pufr_pkg::st_start: begin
            if (rise_start) state_nxt = pufr_pkg::st_timing;
         end
         pufr_pkg::st_timing: begin
            if (vout_above_uv) begin
               state_nxt = pufr_pkg::st_run;
            end else if (timeout_hit) begin
               case (resp)
                  pufr_pkg::RESP_IGNORE: state_nxt = pufr_pkg::st_run;
                  pufr_pkg::RESP_RUN_RETRY: state_nxt = pufr_pkg::st_hold;
                  // shut down now, then retry setting
                  // no retries left means latch off
                  pufr_pkg::RESP_DIS_RETRY: begin
                     state_nxt = retry_ok ? pufr_pkg::st_wait : pufr_pkg::st_latch;
                  end
                  default: state_nxt = pufr_pkg::st_latch;
               endcase
            end
         end
         pufr_pkg::st_run: state_nxt = pufr_pkg::st_run;
         // fault still present after the delay goes to the retry setting
         pufr_pkg::st_hold: begin
            if (dly_done && vout_above_uv) begin
               state_nxt = pufr_pkg::st_run;
            end else if (dly_done) begin
               state_nxt = retry_ok ? pufr_pkg::st_wait : pufr_pkg::st_latch;
            end
         end
         pufr_pkg::st_wait: begin
            if (dly_done) state_nxt = pufr_pkg::st_start;
         end
         pufr_pkg::st_latch: begin
            if (clear_faults || clear_status) state_nxt = pufr_pkg::st_off;
         end
         default: state_nxt = pufr_pkg::st_off;
      endcase
      if (!on_cmd) state_nxt = pufr_pkg::st_off;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         limit_r <= pufr_pkg::LIMIT_RST;
         action_r <= pufr_pkg::ACTION_RST;
      end else if (reg_wr && reg_cmd == pufr_pkg::CMD_LIMIT) begin
         limit_r <= reg_wdata;
      end else if (reg_wr && reg_cmd == pufr_pkg::CMD_ACTION) begin
         action_r <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= pufr_pkg::RDATA_NONE;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd;
         if (reg_rd) rdata_r <= rd_mux;
      end
   end

   // free-running tick; a restart does not realign it, so timings are +0/-1 ms
   always_ff @(posedge clk or posedge rst) begin
      if (rst) tick_cnt_r <= '0;
      else if (ms_tick) tick_cnt_r <= '0;
      else tick_cnt_r <= tick_cnt_r + TICK_W'(1);
   end

   // timer reloads on every start, first or retry
   always_ff @(posedge clk or posedge rst) begin
      if (rst) elapsed_r <= 16'h0000;
      else if (state_r != pufr_pkg::st_timing) elapsed_r <= 16'h0000;
      else if (ms_tick && elapsed_r != 16'hffff) elapsed_r <= elapsed_r + 16'h0001;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= pufr_pkg::st_off;
         out_en_r <= 1'b0;
         restart_r <= 1'b0;
         event_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         out_en_r <= out_en_nxt;
         restart_r <= restarting;
         event_r <= timeout_hit;
      end
   end

   // a new timeout wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) fault_r <= 1'b0;
      else fault_r <= (timeout_hit && resp != pufr_pkg::RESP_IGNORE) || (fault_r && !clear_any);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) retries_r <= 3'h0;
      else if (fresh_start) retries_r <= retry_set;
      else if (restarting && retry_set != pufr_pkg::RETRY_FOREVER && retries_r != 3'h0)
         retries_r <= retries_r - 3'h1;
   end

   tmo_cause_a: assert property (@(posedge clk) disable iff (rst)
      event_r |-> $past(elapsed_r) >= $past(limit_r) && !$past(vout_above_uv))
      else $error("timeout raised before the limit");
   zero_limit_a: assert property (@(posedge clk) disable iff (rst)
      event_r |-> $past(limit_r) != 16'h0000)
      else $error("timeout raised with zero limit");
   ignore_runs_a: assert property (@(posedge clk) disable iff (rst)
      timeout_hit && resp == pufr_pkg::RESP_IGNORE |=> out_en_r && !restart_r ##1 out_en_r)
      else $error("ignored timeout disturbed the output");
   hold_on_a: assert property (@(posedge clk) disable iff (rst)
      timeout_hit && resp == pufr_pkg::RESP_RUN_RETRY |=> out_en_r && state_r == pufr_pkg::st_hold)
      else $error("output dropped during run delay");
   disable_now_a: assert property (@(posedge clk) disable iff (rst)
      timeout_hit && resp == pufr_pkg::RESP_DIS_RETRY |=> !out_en_r)
      else $error("output not disabled on timeout");
   latch_off_a: assert property (@(posedge clk) disable iff (rst)
      state_r == pufr_pkg::st_latch && on_cmd && !clear_faults && !clear_status
      |=> state_r == pufr_pkg::st_latch && !out_en_r)
      else $error("latched state left without a clear");
   clear_fault_a: assert property (@(posedge clk) disable iff (rst)
      state_r == pufr_pkg::st_latch && clear_faults |=> !fault_r ##1 state_r != pufr_pkg::st_latch)
      else $error("clear did not release the fault");
   off_clears_a: assert property (@(posedge clk) disable iff (rst)
      !on_cmd |=> !out_en_r && !fault_r && state_r == pufr_pkg::st_off)
      else $error("command off did not clear");
   retry_count_a: assert property (@(posedge clk) disable iff (rst)
      restarting |-> retry_set == pufr_pkg::RETRY_FOREVER || retries_r != 3'h0)
      else $error("restart without retries left");
   retry_dec_a: assert property (@(posedge clk) disable iff (rst)
      restart_r && retry_set != pufr_pkg::RETRY_FOREVER && $past(retry_set) == retry_set
      |-> retries_r == 3'($past(retries_r) - 3'h1))
      else $error("retry count not decremented");

   cov_timeout_c: cover property (@(posedge clk) disable iff (rst) event_r);
   cov_restart_c: cover property (@(posedge clk) disable iff (rst) restart_r ##[1:20] out_en_r);
   cov_latch_c: cover property (@(posedge clk) disable iff (rst)
      state_r == pufr_pkg::st_wait ##[1:1000] state_r == pufr_pkg::st_latch);
endmodule

// ---- verification/pufr_conv_model.sv ----
module pufr_conv_model #(
   parameter int TON_DLY = 3,
   parameter int RISE = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // converter side
   input wire logic out_enable,
   input wire logic good,
   output logic rise_start,
   output logic vout_above_uv
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt;
   // a failing stage never lifts the output, the timer must catch it
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         rise_start <= 1'b0;
         vout_above_uv <= 1'b0;
      end else begin
         rise_start <= 1'b0;
         if (!out_enable) begin
            cnt <= 0;
            vout_above_uv <= 1'b0;
         end else begin
            if (cnt < TON_DLY + RISE + 1) cnt <= cnt + 1;
            if (cnt == TON_DLY) rise_start <= 1'b1;
            if (cnt == TON_DLY + RISE && good) vout_above_uv <= 1'b1;
         end
      end
   end
endmodule

// ---- verification/pufr_top_bench.sv ----
module pufr_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int MS = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_cmd = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic on_cmd = 1'b0;
   logic clear_faults = 1'b0;
   logic clear_status = 1'b0;
   logic good = 1'b0;
   logic [7:0] vout_unit_ms = 8'h01;
   logic [15:0] reg_rdata;
   logic reg_rvalid, rise_start, vout_above_uv, out_enable, restart_pulse;
   logic timeout_event, timeout_fault;
   logic [2:0] retries_left;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   int n;

   always #12.5 clk = ~clk;

   pufr_top #(.MS_CYCLES(MS), .UNIT_W(8)) u_dut (.clk, .rst, .reg_wr, .reg_rd, .reg_cmd,
      .reg_wdata, .reg_rdata, .reg_rvalid, .on_cmd, .rise_start, .vout_above_uv,
      .clear_faults, .clear_status, .vout_unit_ms, .out_enable, .restart_pulse,
      .timeout_event, .timeout_fault, .retries_left);
   pufr_conv_model u_conv (.clk, .rst, .out_enable, .good, .rise_start, .vout_above_uv);

   task report_and_stop;
      if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // hang guard, the whole sequence needs well under half of this
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop;
      end
   end

   task step(input int k);
      repeat (k) begin
         @(posedge clk);
         #1;
      end
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task chk_in(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         fails++;
         $display("FAIL %0t cycles %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task wr(input logic [7:0] c, input logic [15:0] d);
      reg_cmd = c;
      reg_wdata = d;
      reg_wr = 1'b1;
      step(1);
      reg_wr = 1'b0;
      // let an edge pass so a following strobe is not raised in the same step
      step(1);
   endtask
   task rd(input logic [7:0] c, input logic [15:0] exp);
      reg_cmd = c;
      reg_rd = 1'b1;
      step(1);
      reg_rd = 1'b0;
      chk(reg_rvalid, 1'b1);
      chk(reg_rdata, exp);
      step(1);
   endtask
   // sel 0 timeout pulse, 1 restart pulse, 2 output dropped
   task wait_ev(input int sel, input int lim);
      n = 0;
      while (n < lim && !((sel == 0 && timeout_event === 1'b1) ||
            (sel == 1 && restart_pulse === 1'b1) || (sel == 2 && out_enable === 1'b0))) begin
         step(1);
         n++;
      end
   endtask
   task power(input logic [15:0] lim, input logic [7:0] act, input logic g);
      on_cmd = 1'b0;
      step(2);
      wr(pufr_pkg::CMD_LIMIT, lim);
      wr(pufr_pkg::CMD_ACTION, {8'h00, act});
      good = g;
      on_cmd = 1'b1;
      step(3);
      chk(out_enable, 1'b1);
   endtask

   task t_regs;
      rd(pufr_pkg::CMD_LIMIT, 16'h0000);
      rd(pufr_pkg::CMD_ACTION, 16'h0000);
      wr(pufr_pkg::CMD_LIMIT, 16'hbeef);
      wr(pufr_pkg::CMD_ACTION, 16'h12a5);
      wr(8'h70, 16'h1234);
      rd(pufr_pkg::CMD_LIMIT, 16'hbeef);
      rd(pufr_pkg::CMD_ACTION, 16'h00a5);
      rd(8'h70, 16'h0000);
   endtask
   task t_times;
      power(16'h0000, 8'h88, 1'b0);
      wait_ev(0, 300);
      chk_in(n, 300, 300);
      power(16'h0002, 8'h00, 1'b0);
      wait_ev(0, 100);
      chk_in(n, MS, 3 * MS);
      step(40);
      chk(timeout_fault, 1'b0);
      chk(out_enable, 1'b1);
      power(16'h0002, 8'h88, 1'b1);
      wait_ev(0, 100);
      chk_in(n, 100, 100);
   endtask
   task t_once;
      power(16'h0002, 8'h88, 1'b0);
      wait_ev(0, 100);
      chk(out_enable, 1'b0);
      chk(timeout_fault, 1'b1);
      chk(retries_left, 3'h1);
      wait_ev(1, 100);
      chk_in(n, 0, 2 * MS);
      chk(out_enable, 1'b1);
      chk(retries_left, 3'h0);
      wait_ev(0, 100);
      chk_in(n, MS, 3 * MS);
      wait_ev(1, 200);
      chk_in(n, 200, 200);
      chk(out_enable, 1'b0);
   endtask
   task t_codes;
      vout_unit_ms = 8'h02;
      for (int c = 0; c < 8; c++) begin
         power(16'h0002, 8'h88 | 8'(c), 1'b0);
         wait_ev(0, 100);
         wait_ev(1, 2200);
         chk_in(n, ((2 << c) - 1) * MS - 2, (2 << c) * MS + 4);
      end
      on_cmd = 1'b0;
      step(2);
      vout_unit_ms = 8'h01;
   endtask
   task t_latch;
      power(16'h0002, 8'hc8, 1'b0);
      wait_ev(0, 100);
      chk(out_enable, 1'b0);
      wait_ev(1, 200);
      chk_in(n, 200, 200);
      clear_faults = 1'b1;
      step(1);
      clear_faults = 1'b0;
      step(3);
      chk(timeout_fault, 1'b0);
      chk(out_enable, 1'b1);
      wait_ev(0, 100);
      clear_status = 1'b1;
      step(1);
      clear_status = 1'b0;
      step(3);
      chk(timeout_fault, 1'b0);
      wait_ev(0, 100);
      on_cmd = 1'b0;
      step(2);
      chk(timeout_fault, 1'b0);
      on_cmd = 1'b1;
      step(3);
      chk(out_enable, 1'b1);
      wait_ev(0, 100);
      rst = 1'b1;
      step(2);
      rst = 1'b0;
      chk(timeout_fault, 1'b0);
      rd(pufr_pkg::CMD_LIMIT, 16'h0000);
   endtask
   task t_seq;
      power(16'h0002, 8'h80, 1'b0);
      wait_ev(0, 100);
      wait_ev(1, 200);
      chk_in(n, 200, 200);
      chk(out_enable, 1'b0);
      power(16'h0002, 8'h49, 1'b0);
      wait_ev(0, 100);
      chk(out_enable, 1'b1);
      wait_ev(2, 100);
      chk_in(n, MS - 2, 2 * MS + 4);
      wait_ev(1, 100);
      chk_in(n, MS - 2, 2 * MS + 4);
      power(16'h0002, 8'hb8, 1'b0);
      for (int i = 0; i < 3; i++) begin
         wait_ev(0, 100);
         wait_ev(1, 100);
         chk_in(n, 0, 2 * MS);
         chk(retries_left, pufr_pkg::RETRY_FOREVER);
      end
      on_cmd = 1'b0;
      step(2);
      chk(out_enable, 1'b0);
   endtask

   initial begin
      step(8);
      rst = 1'b0;
      t_regs;
      t_times;
      t_once;
      t_codes;
      t_latch;
      t_seq;
      report_and_stop;
   end
endmodule
